// ### rtl/sls_flag_shift.v
`timescale 1ns/1ps
`include "sls_loop_regs.vh"
// Serialises a flag or a data byte, LSB first, with zero insertion in data bytes only
module sls_flag_shift (
	// Clock and reset
	input  wire       clk_i,
	input  wire       reset_i,
	// Control
	input  wire       load_flag_i,
	input  wire       load_data_i,
	input  wire [7:0] data_i,
	input  wire       step_i,
	// Output
	output reg        bit_o,
	output wire       done_o
);
	reg [7:0] shreg;
	reg [3:0] left;
	reg       stuff_on;
	reg [2:0] ones;
	reg       stuff_now;

	assign done_o = (left == 4'h0);

	always @(posedge clk_i) begin
		if (reset_i) begin
			shreg     <= `SLS_FLAG_PATTERN;
			left      <= 4'h0;
			stuff_on  <= 1'b0;
			ones      <= 3'h0;
			bit_o     <= 1'b1;
			stuff_now <= 1'b0;
		end else if (load_flag_i) begin
			shreg    <= `SLS_FLAG_PATTERN;
			left     <= 4'h8;
			stuff_on <= 1'b0;
			ones     <= 3'h0;
		end else if (load_data_i) begin
			shreg    <= data_i;
			left     <= 4'h8;
			stuff_on <= 1'b1;
		end else if (step_i && left != 4'h0) begin
			// Five ones in data force a zero so data never mimics a flag
			if (stuff_on && ones == 3'h5) begin
				bit_o <= 1'b0;
				ones  <= 3'h0;
			end else begin
				bit_o <= shreg[0];
				shreg <= {1'b0, shreg[7:1]};
				left  <= left - 4'h1;
				ones  <= shreg[0] ? ones + 3'h1 : 3'h0;
			end
		end
	end
endmodule

// ### rtl/sls_loop_regs.vh
`ifndef SLS_LOOP_REGS_VH
`define SLS_LOOP_REGS_VH
`define SLS_CTL_LOOP_BIT    1
`define SLS_CTL_GOACT_BIT   4
`define SLS_STS_ONLOOP_BIT  1
`define SLS_STS_SENDING_BIT 4
`define SLS_FLAG_PATTERN    8'h7E
`define SLS_ONES_FOR_EOP    3'h7
`define SLS_ST_IDLE         3'h0
`define SLS_ST_WAIT_ON      3'h1
`define SLS_ST_ON_HUNT      3'h2
`define SLS_ST_ON_ARMED     3'h3
`define SLS_ST_SEND         3'h4
`define SLS_ST_CLOSE        3'h5
`define SLS_ST_OFF_WAIT     3'h6
`endif

// ### rtl/sls_loop_station.v
`timescale 1ns/1ps
`include "sls_loop_regs.vh"
// Secondary loop station: repeater path, go-on-loop, respond to poll, orderly exit
module sls_loop_station (
	// Clock and reset
	input  wire       clk_i,
	input  wire       reset_i,
	// Serial bit timing
	input  wire       bit_tick_i,
	input  wire       rx_i,
	output reg        tx_o,
	// Control bits from misc_tx_rx_control
	input  wire [7:0] misc_tx_rx_control_i,
	input  wire       nrzi_i,
	input  wire       abort_on_underrun_i,
	input  wire       flag_idle_i,
	input  wire       ext_status_ie_i,
	// Transmit data
	input  wire [7:0] tx_data_i,
	input  wire       tx_data_valid_i,
	input  wire       tx_last_i,
	output wire       tx_data_ready_o,
	// Status
	output wire [7:0] misc_loop_status_o,
	output reg        break_abort_o,
	output reg        hunt_o,
	output reg        ext_status_irq_o,
	output wire       normal_mode_o,
	output wire       idle_abort_o,
	output wire       idle_mark_o
);
	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [2:0] ones;
	reg        rx_d;
	reg        on_loop;
	reg        sending;
	reg        delay_on;
	reg        connected;
	reg        loop_active;
	reg        last_pending;
	reg        got_flag;
	reg        extra_zero;
	reg        tx_level;
	reg        load_flag;
	reg        load_data;
	wire       sh_bit;
	wire       sh_done;
	wire       loop_sel;
	wire       goact;
	wire       eop_seen;
	wire       flag_seen;
	wire       repeat_bit;

	assign loop_sel = misc_tx_rx_control_i[`SLS_CTL_LOOP_BIT];
	assign goact    = misc_tx_rx_control_i[`SLS_CTL_GOACT_BIT];

	// Seventh one in a row ends a poll; a zero after six ones is a flag
	assign eop_seen  = bit_tick_i && rx_i && ones == 3'h6;
	assign flag_seen = bit_tick_i && !rx_i && ones == 3'h6;

	assign misc_loop_status_o = {3'h0, sending, 2'h0, on_loop, 1'b0};

	// Loop mode overrides idle and underrun choices
	assign normal_mode_o = !loop_active;
	assign idle_abort_o  = loop_active ? 1'b0 : abort_on_underrun_i;
	assign idle_mark_o   = loop_active ? 1'b0 : !flag_idle_i;

	assign tx_data_ready_o = (state == `SLS_ST_SEND) && sh_done && !last_pending;

	// One-bit delay or gate-only echo of the receive line
	assign repeat_bit = delay_on ? rx_d : rx_i;

	sls_flag_shift u_shift (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.load_flag_i (load_flag),
		.load_data_i (load_data),
		.data_i      (tx_data_i),
		.step_i      (bit_tick_i),
		.bit_o       (sh_bit),
		.done_o      (sh_done)
	);

	always @* begin
		next_state = state;
		load_flag  = 1'b0;
		load_data  = 1'b0;
		case (state)
			`SLS_ST_IDLE: begin
				if (loop_sel) begin
					next_state = `SLS_ST_WAIT_ON;
					load_flag  = 1'b1;
				end
			end
			`SLS_ST_WAIT_ON: begin
				if (!loop_sel)
					next_state = `SLS_ST_IDLE;
				else if (goact && bit_tick_i && rx_i && ones == 3'h6)
					next_state = `SLS_ST_ON_HUNT;
			end
			`SLS_ST_ON_HUNT: begin
				if (!loop_sel)
					next_state = `SLS_ST_OFF_WAIT;
				else if (got_flag && eop_seen && goact) begin
					next_state = `SLS_ST_SEND;
					load_flag  = 1'b1;
				end
			end
			`SLS_ST_SEND: begin
				if (sh_done) begin
					if (tx_data_valid_i && !last_pending)
						load_data = 1'b1;
					else if (last_pending || !goact) begin
						next_state = `SLS_ST_CLOSE;
						load_flag  = 1'b1;
					end else
						load_flag = 1'b1;
				end
			end
			`SLS_ST_CLOSE: begin
				if (sh_done && bit_tick_i && !extra_zero)
					next_state = loop_sel ? `SLS_ST_ON_HUNT : `SLS_ST_OFF_WAIT;
			end
			`SLS_ST_OFF_WAIT: begin
				if (hunt_o || eop_seen || (bit_tick_i && rx_i && ones == 3'h6))
					next_state = `SLS_ST_IDLE;
			end
			default: next_state = `SLS_ST_IDLE;
		endcase
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			state            <= `SLS_ST_IDLE;
			ones             <= 3'h0;
			rx_d             <= 1'b1;
			on_loop          <= 1'b0;
			sending          <= 1'b0;
			delay_on         <= 1'b0;
			connected        <= 1'b0;
			loop_active      <= 1'b0;
			last_pending     <= 1'b0;
			got_flag         <= 1'b0;
			extra_zero       <= 1'b0;
			tx_level         <= 1'b1;
			tx_o             <= 1'b1;
			break_abort_o    <= 1'b0;
			hunt_o           <= 1'b0;
			ext_status_irq_o <= 1'b0;
		end else begin
			state <= next_state;
			if (bit_tick_i) begin
				rx_d <= rx_i;
				ones <= rx_i ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
			end
			ext_status_irq_o <= 1'b0;
			break_abort_o    <= 1'b0;
			if (state == `SLS_ST_IDLE && next_state == `SLS_ST_WAIT_ON) begin
				connected   <= 1'b1;
				loop_active <= 1'b1;
				delay_on    <= 1'b0;
			end
			if (state == `SLS_ST_WAIT_ON && next_state == `SLS_ST_ON_HUNT) begin
				break_abort_o    <= 1'b1;
				ext_status_irq_o <= ext_status_ie_i;
				delay_on         <= 1'b1;
				on_loop          <= 1'b1;
				hunt_o           <= 1'b1;
				got_flag         <= 1'b0;
			end
			if (state == `SLS_ST_ON_HUNT && flag_seen && hunt_o) begin
				hunt_o   <= 1'b0;
				got_flag <= 1'b1;
			end
			if (next_state == `SLS_ST_SEND && state == `SLS_ST_ON_HUNT) begin
				break_abort_o    <= 1'b1;
				ext_status_irq_o <= ext_status_ie_i;
				hunt_o           <= 1'b1;
				sending          <= 1'b1;
			end
			if (state == `SLS_ST_SEND && load_data)
				last_pending <= tx_last_i;
			if (state == `SLS_ST_SEND && load_flag && next_state == `SLS_ST_CLOSE) begin
				last_pending <= 1'b0;
				// Shared zero would leave tx inverted relative to rx
				extra_zero <= nrzi_i && (tx_level != rx_i);
			end
			if (state == `SLS_ST_CLOSE && sh_done && bit_tick_i && extra_zero)
				extra_zero <= 1'b0;
			if (state == `SLS_ST_CLOSE && next_state != `SLS_ST_CLOSE) begin
				sending <= 1'b0;
				if (!loop_sel)
					connected <= 1'b0;
			end
			if (state == `SLS_ST_OFF_WAIT && next_state == `SLS_ST_IDLE) begin
				break_abort_o    <= 1'b1;
				ext_status_irq_o <= ext_status_ie_i;
				on_loop     <= 1'b0;
				delay_on    <= 1'b0;
				connected   <= 1'b0;
				loop_active <= 1'b0;
				hunt_o      <= 1'b1;
				got_flag    <= 1'b0;
			end
			if (state == `SLS_ST_WAIT_ON && !loop_sel) begin
				connected   <= 1'b0;
				loop_active <= 1'b0;
			end
			// NRZI holds level for one, toggles for zero
			if (bit_tick_i) begin
				if (state == `SLS_ST_SEND || state == `SLS_ST_CLOSE) begin
					if (nrzi_i)
						tx_level <= (extra_zero && sh_done) ? !tx_level : (sh_bit ? tx_level : !tx_level);
					else
						tx_level <= (extra_zero && sh_done) ? 1'b0 : sh_bit;
				end else
					tx_level <= repeat_bit;
			end
			if (sending)
				tx_o <= tx_level;
			else if (connected)
				tx_o <= repeat_bit;
			else
				tx_o <= 1'b1;
		end
	end
endmodule

// ### test/sls_loop_partner.sv
`timescale 1ns/1ps
// Far side of the loop: a marking line with a free bit clock, bits sent LSB first
module sls_loop_partner (
	// Clock and reset
	input  wire clk_i,
	input  wire reset_i,
	// Line
	output reg  bit_tick_o,
	output reg  rx_o
);
	reg [1:0]  div;
	reg [15:0] sh;
	integer    left;
	initial left = 0;
	task send(input [15:0] bits, input integer n);
		begin
			wait (left == 0);
			sh = bits;
			left = n;
			wait (left == 0);
		end
	endtask
	always @(posedge clk_i) begin
		if (reset_i) begin
			div <= 2'h0;
			bit_tick_o <= 1'b0;
			rx_o <= 1'b1;
		end else begin
			div <= div + 2'h1;
			bit_tick_o <= (div == 2'h3);
			// Line changes a cycle before its tick so the sample never races it
			if (div == 2'h2) begin
				// Loop marks idle between polls, so seven ones follow a burst unless the next send starts within seven bits
				rx_o <= (left > 0) ? sh[0] : 1'b1;
				if (left > 0) begin
					sh <= sh >> 1;
					left <= left - 1;
				end
			end
		end
	end
endmodule

// ### test/sls_loop_station_monitor.sv
`timescale 1ns/1ps
module sls_loop_station_monitor (
	input wire       clk_i,
	input wire       reset_i,
	input wire       bit_tick_i,
	input wire       rx_i,
	input wire       tx_o,
	input wire [7:0] misc_tx_rx_control_i,
	input wire       ext_status_ie_i,
	input wire       tx_data_ready_o,
	input wire [7:0] misc_loop_status_o,
	input wire       break_abort_o,
	input wire       hunt_o,
	input wire       ext_status_irq_o,
	input wire       normal_mode_o,
	input wire       idle_abort_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire on_l = misc_loop_status_o[1];
	wire snd = misc_loop_status_o[4];
	property p_rst; $fell(reset_i) |-> misc_loop_status_o == 8'h00 && tx_o && !hunt_o; endproperty
	a_rst: assert property (p_rst) else $error("status not clear after reset");
	property p_rsv; misc_loop_status_o[7:5] == 3'h0 && misc_loop_status_o[3:2] == 2'h0 && !misc_loop_status_o[0]; endproperty
	a_rsv: assert property (p_rsv) else $error("unused status bit set");
	property p_on; $rose(on_l) |-> hunt_o && (break_abort_o || $past(break_abort_o)) && $past(misc_tx_rx_control_i[4]); endproperty
	a_on: assert property (p_on) else $error("on-loop without break and hunt");
	property p_snd; $rose(snd) |-> on_l && (break_abort_o || $past(break_abort_o)); endproperty
	a_snd: assert property (p_snd) else $error("sending without end-of-poll");
	property p_irq; break_abort_o && ext_status_ie_i |-> ##[0:1] ext_status_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("status interrupt missing");
	property p_rdy; tx_data_ready_o |-> on_l; endproperty
	a_rdy: assert property (p_rdy) else $error("data taken while off loop");
	property p_echo; misc_tx_rx_control_i[1] && $past(misc_tx_rx_control_i[1], 2) && !on_l && !$past(on_l, 2)
		&& !snd |-> tx_o == $past(rx_i); endproperty
	a_echo: assert property (p_echo) else $error("repeater path broken");
	property p_norm; on_l |-> !normal_mode_o && !idle_abort_o; endproperty
	a_norm: assert property (p_norm) else $error("normal settings honoured on loop");
	c_on: cover property ($rose(on_l));
	c_snd: cover property ($rose(snd));
	c_done: cover property ($fell(snd));
	c_off: cover property ($fell(on_l));
endmodule
bind sls_loop_station sls_loop_station_monitor mon (.clk_i(clk_i), .reset_i(reset_i), .bit_tick_i(bit_tick_i),
	.rx_i(rx_i), .tx_o(tx_o), .misc_tx_rx_control_i(misc_tx_rx_control_i), .ext_status_ie_i(ext_status_ie_i),
	.tx_data_ready_o(tx_data_ready_o), .misc_loop_status_o(misc_loop_status_o), .break_abort_o(break_abort_o),
	.hunt_o(hunt_o), .ext_status_irq_o(ext_status_irq_o), .normal_mode_o(normal_mode_o),
	.idle_abort_o(idle_abort_o));

// ### test/sls_loop_station_tb_top.sv
`timescale 1ns/1ps
module sls_loop_station_tb_top;
	reg         clk_i, reset_i, nrzi, aou, fidle, ie, valid, last, brk_seen;
	reg  [7:0]  ctl, tx_data;
	reg  [31:0] seed;
	wire        tick, rx, tx_o, ready, brk, hunt, irq, norm, iab, imk;
	wire [7:0]  sts;
	integer     n_errors, samples_checked, cyc, i;
	sls_loop_partner part (.clk_i(clk_i), .reset_i(reset_i), .bit_tick_o(tick), .rx_o(rx));
	sls_loop_station dut (.clk_i(clk_i), .reset_i(reset_i), .bit_tick_i(tick), .rx_i(rx), .tx_o(tx_o),
		.misc_tx_rx_control_i(ctl), .nrzi_i(nrzi), .abort_on_underrun_i(aou), .flag_idle_i(fidle),
		.ext_status_ie_i(ie), .tx_data_i(tx_data), .tx_data_valid_i(valid), .tx_last_i(last),
		.tx_data_ready_o(ready), .misc_loop_status_o(sts), .break_abort_o(brk), .hunt_o(hunt),
		.ext_status_irq_o(irq), .normal_mode_o(norm), .idle_abort_o(iab), .idle_mark_o(imk));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task print_verdict;
		begin
			$display("checked %0d mismatches %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task cmp8(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task step;
		begin
			@(posedge clk_i);
			#1;
		end
	endtask
	// Bounded wait on one status bit, then compare it
	task wait_sts(input integer b, input v, input integer lim);
		integer k;
		begin
			for (k = 0; k < lim && sts[b] !== v; k = k + 1)
				step;
			cmp8({7'h0, sts[b]}, {7'h0, v});
		end
	endtask
	task feed(input [7:0] d, input l);
		integer k;
		begin
			tx_data = d;
			last = l;
			valid = 1'b1;
			// Ready is judged between edges; the following edge takes the byte
			for (k = 0; k < 3000 && ready !== 1'b1; k = k + 1)
				step;
			step;
			valid = 1'b0;
			last = 1'b0;
			step;
		end
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (brk === 1'b1)
			brk_seen <= 1'b1;
		if (cyc == 40000) begin
			n_errors = n_errors + 1;
			print_verdict;
		end
	end
	initial begin
		{nrzi, aou, fidle, valid, last, brk_seen} = 6'h00;
		{ctl, tx_data} = 16'h0000;
		ie = 1'b1;
		seed = 32'h5439;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		reset_i = 1'b1;
		repeat (3) step;
		reset_i = 1'b0;
		cmp8(sts, 8'h00);
		cmp8({hunt, tx_o}, 8'h01);
		ctl = 8'h02;
		aou = 1'b1;
		fidle = 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			// Runs of ones kept short so no end-of-poll appears
			fork
				part.send(seed[15:0] & 16'h7777, 16);
				begin
					repeat (4) begin
						wait (tick === 1'b1);
						step;
						cmp8({7'h0, tx_o}, {7'h0, rx});
					end
				end
			join
		end
		$display("test echo done");
		ctl = 8'h12;
		wait_sts(1, 1'b1, 400);
		cmp8({7'h0, hunt}, 8'h01);
		cmp8({5'h0, imk, iab, norm}, 8'h00);
		ctl = 8'h02;
		part.send(16'h007E, 8);
		wait_sts(4, 1'b0, 1);
		repeat (20) step;
		cmp8({7'h0, hunt}, 8'h00);
		repeat (80) step;
		cmp8(sts, 8'h02);
		$display("test on loop done");
		ctl = 8'h12;
		nrzi = 1'b1;
		brk_seen = 1'b0;
		part.send(16'h007E, 8);
		wait_sts(4, 1'b1, 400);
		step;
		cmp8({6'h0, brk_seen, hunt}, 8'h03);
		seed = xs(seed);
		feed(seed[7:0], 1'b0);
		feed(seed[15:8], 1'b0);
		ctl = 8'h02;
		feed(seed[23:16], 1'b1);
		wait_sts(4, 1'b0, 2000);
		cmp8(sts, 8'h02);
		$display("test send done");
		ctl = 8'h00;
		brk_seen = 1'b0;
		part.send(16'h007E, 8);
		wait_sts(1, 1'b0, 400);
		cmp8({7'h0, norm}, 8'h01);
		step;
		cmp8({6'h0, brk_seen, hunt}, 8'h03);
		fidle = 1'b0;
		step;
		cmp8({6'h0, imk, iab}, 8'h03);
		$display("test exit done");
		ctl = 8'h02;
		step;
		ctl = 8'h12;
		part.send(16'h007E, 8);
		wait_sts(1, 1'b1, 400);
		reset_i = 1'b1;
		ctl = 8'h00;
		repeat (3) step;
		reset_i = 1'b0;
		cmp8(sts, 8'h00);
		cmp8({5'h0, hunt, tx_o, norm}, 8'h03);
		$display("test reset done");
		print_verdict;
	end
endmodule
